// ==== rtl/dme_pkg.sv ====
package dme_pkg;
  localparam int PM_WORDS = 1024;
  localparam int PM_W = 16;
  localparam int PC_W = 10;
  localparam int GPR_COUNT = 32;
  localparam int IO_COUNT = 64;
  localparam int SRAM_BYTES = 128;
  localparam logic [7:0] IO_BASE = 8'h20;
  localparam logic [7:0] SRAM_BASE = 8'h60;
  localparam logic [7:0] DS_END = 8'hE0;
  localparam int EE_BYTES = 128;
  localparam int EE_AW = 7;
  localparam logic [5:0] IO_EE_CTRL = 6'h1C;
  localparam logic [5:0] IO_EE_DATA = 6'h1D;
  localparam logic [5:0] IO_EE_ADDR = 6'h1E;
  localparam int CTRL_RD = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_ARM = 2;
  localparam int CTRL_IRQ_EN = 3;
  localparam logic [7:0] EE_DATA_RESET = 8'h00;
  localparam logic [2:0] WR_STALL_CYCLES = 3'h2;
  localparam logic [2:0] RD_STALL_CYCLES = 3'h4;
  localparam logic [2:0] ARM_HOLD_CYCLES = 3'h4;
  localparam real CLK_PERIOD_NS = 40.0;
  localparam real PROG_TIME_MS = 8.3;
  localparam int PROG_CYCLES_DEF = int'($ceil(PROG_TIME_MS * 1.0e6 / CLK_PERIOD_NS));

  typedef enum logic [2:0] {
    EE_IDLE = 3'b001,
    EE_RD_STALL = 3'b010,
    EE_WR_STALL = 3'b100
  } dme_ee_state_t;

  typedef enum logic [3:0] {
    RG_GPR = 4'b0001,
    RG_IO = 4'b0010,
    RG_SRAM = 4'b0100,
    RG_NONE = 4'b1000
  } dme_region_t;

  typedef struct packed {
    logic [7:0] addr;
    logic is_io;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dme_bus_req_t;

  typedef struct packed {
    logic wr;
    logic [PC_W-1:0] addr;
    logic [PM_W-1:0] data;
  } dme_pm_load_t;
endpackage : dme_pkg

// ==== rtl/dme_top.sv ====
`timescale 1ns/1ns
module dme_top
  import dme_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input wire logic clock, // System clock, 25 MHz
  input wire logic arst_n, // Async reset, active low
  input wire dme_bus_req_t bus_req, // Core data or I/O access
  input wire dme_pm_load_t pm_load, // Program memory fill port
  input wire logic pc_load, // Load program counter
  input wire logic [PC_W-1:0] pc_target, // Jump target word
  output logic [7:0] bus_rdata_q, // Read data, one cycle after rd
  output logic cpu_stall_q, // Core halt request
  output logic [PC_W-1:0] program_counter_q, // Current fetch address
  output logic [PM_W-1:0] instr_word_q, // Fetched instruction word
  output logic ee_ready_irq_q // EEPROM ready interrupt request
);
  localparam int PCW = $clog2(PROG_CYCLES + 1);

  function automatic dme_region_t dme_region(input logic [7:0] a);
    if (a < IO_BASE) begin
      return RG_GPR;
    end else if (a < SRAM_BASE) begin
      return RG_IO;
    end else if (a < DS_END) begin
      return RG_SRAM;
    end
    return RG_NONE;
  endfunction : dme_region

  logic [PM_W-1:0] pm_mem [PM_WORDS];
  logic [7:0] gpr_mem [GPR_COUNT];
  logic [7:0] io_mem [IO_COUNT];
  logic [7:0] sram_mem [SRAM_BYTES];
  logic [7:0] ee_mem [EE_BYTES];

  logic [7:0] eff_addr;
  dme_region_t region;
  logic [5:0] io_idx;
  logic ctrl_wr, data_wr, addr_wr, other_io_wr, ctrl_rd, addr_rd;
  logic launch, rd_launch, commit;

  dme_ee_state_t state_q, state_d;
  logic [2:0] stall_cnt_q, stall_cnt_d;
  logic stall_d;
  logic arm_q, arm_d;
  logic [2:0] arm_cnt_q, arm_cnt_d;
  logic busy_q, busy_d;
  logic [PCW-1:0] prog_cnt_q, prog_cnt_d;
  logic irq_en_q, irq_en_d;
  logic irq_d;
  logic [7:0] data_q, data_d;
  logic [EE_AW-1:0] ee_addr_q, ee_addr_d;
  logic [7:0] rdata_d;
  logic [PC_W-1:0] pc_d;
  logic [PM_W-1:0] instr_d;

  // I/O accesses land in the same map, offset past the working registers
  always_comb begin
    eff_addr = bus_req.is_io ? 8'(IO_BASE + {2'b00, bus_req.addr[5:0]}) : bus_req.addr;
    region = dme_region(eff_addr);
    io_idx = 6'(eff_addr - IO_BASE);
    ctrl_wr = bus_req.wr && region == RG_IO && io_idx == IO_EE_CTRL;
    data_wr = bus_req.wr && region == RG_IO && io_idx == IO_EE_DATA;
    addr_wr = bus_req.wr && region == RG_IO && io_idx == IO_EE_ADDR;
    other_io_wr = bus_req.wr && region == RG_IO && !ctrl_wr && !data_wr && !addr_wr;
    ctrl_rd = bus_req.rd && region == RG_IO && io_idx == IO_EE_CTRL;
    addr_rd = bus_req.rd && region == RG_IO && io_idx == IO_EE_ADDR;
  end

  always_comb begin
    state_d = state_q;
    stall_cnt_d = stall_cnt_q;
    stall_d = 1'b0;
    arm_d = arm_q;
    arm_cnt_d = arm_cnt_q;
    busy_d = busy_q;
    prog_cnt_d = prog_cnt_q;
    irq_en_d = irq_en_q;
    data_d = data_q;
    ee_addr_d = ee_addr_q;
    commit = 1'b0;
    // Strobe without a live arm bit is dropped
    launch = ctrl_wr && bus_req.wdata[CTRL_WR] && arm_q && !busy_q && state_q == EE_IDLE;
    rd_launch = ctrl_wr && bus_req.wdata[CTRL_RD] && !busy_q && state_q == EE_IDLE && !launch;
    if (ctrl_wr) begin
      irq_en_d = bus_req.wdata[CTRL_IRQ_EN];
    end
    if (ctrl_wr && bus_req.wdata[CTRL_ARM]) begin
      arm_d = 1'b1;
      arm_cnt_d = ARM_HOLD_CYCLES - 3'h1;
    end else if (arm_q) begin
      if (arm_cnt_q == 3'h0) begin
        arm_d = 1'b0;
      end else begin
        arm_cnt_d = arm_cnt_q - 3'h1;
      end
    end
    if (launch) begin
      busy_d = 1'b1;
      prog_cnt_d = PCW'(PROG_CYCLES - 1);
    end else if (busy_q) begin
      if (prog_cnt_q == '0) begin
        busy_d = 1'b0;
        commit = 1'b1;
      end else begin
        prog_cnt_d = prog_cnt_q - PCW'(1'b1);
      end
    end
    // Not locked while busy; the byte committed is the one held when programming ends
    if (data_wr) begin
      data_d = bus_req.wdata;
    end
    if (addr_wr) begin
      ee_addr_d = bus_req.wdata[EE_AW-1:0];
    end
    case (state_q)
      EE_IDLE: begin
        if (launch) begin
          state_d = EE_WR_STALL;
          stall_cnt_d = WR_STALL_CYCLES - 3'h1;
          stall_d = 1'b1;
        end else if (rd_launch) begin
          state_d = EE_RD_STALL;
          stall_cnt_d = RD_STALL_CYCLES - 3'h1;
          stall_d = 1'b1;
        end
      end
      EE_WR_STALL: begin
        stall_d = stall_cnt_q != 3'h0;
        stall_cnt_d = stall_cnt_q - 3'h1;
        if (stall_cnt_q == 3'h0) begin
          state_d = EE_IDLE;
          stall_cnt_d = 3'h0;
        end
      end
      EE_RD_STALL: begin
        stall_d = stall_cnt_q != 3'h0;
        stall_cnt_d = stall_cnt_q - 3'h1;
        if (stall_cnt_q == 3'h0) begin
          state_d = EE_IDLE;
          stall_cnt_d = 3'h0;
          data_d = ee_mem[ee_addr_q];
        end
      end
      default: begin
        state_d = EE_IDLE;
        stall_cnt_d = 3'h0;
      end
    endcase
    irq_d = irq_en_d && !busy_d;
  end

  always_comb begin
    rdata_d = 8'h00;
    if (bus_req.rd) begin
      case (region)
        RG_GPR: rdata_d = gpr_mem[eff_addr[4:0]];
        RG_SRAM: rdata_d = sram_mem[7'(eff_addr - SRAM_BASE)];
        RG_IO: begin
          if (ctrl_rd) begin
            rdata_d = {4'h0, irq_en_q, arm_q, busy_q, state_q == EE_RD_STALL};
          end else if (io_idx == IO_EE_DATA) begin
            rdata_d = data_q;
          end else if (addr_rd) begin
            rdata_d = {1'b0, ee_addr_q};
          end else begin
            rdata_d = io_mem[io_idx];
          end
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_comb begin
    if (pc_load) begin
      pc_d = pc_target;
    end else if (cpu_stall_q) begin
      pc_d = program_counter_q;
    end else begin
      pc_d = program_counter_q + PC_W'(1'b1);
    end
    instr_d = pm_mem[program_counter_q];
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= EE_IDLE;
      stall_cnt_q <= 3'h0;
      cpu_stall_q <= 1'b0;
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
      busy_q <= 1'b0;
      prog_cnt_q <= '0;
      irq_en_q <= 1'b0;
      ee_ready_irq_q <= 1'b0;
      data_q <= EE_DATA_RESET;
      bus_rdata_q <= 8'h00;
      program_counter_q <= '0;
      instr_word_q <= '0;
    end else begin
      state_q <= state_d;
      stall_cnt_q <= stall_cnt_d;
      cpu_stall_q <= stall_d;
      arm_q <= arm_d;
      arm_cnt_q <= arm_cnt_d;
      busy_q <= busy_d;
      prog_cnt_q <= prog_cnt_d;
      irq_en_q <= irq_en_d;
      ee_ready_irq_q <= irq_d;
      data_q <= data_d;
      bus_rdata_q <= rdata_d;
      program_counter_q <= pc_d;
      instr_word_q <= instr_d;
    end
  end

  // Address has no reset value, software must load it first
  always_ff @(posedge clock) begin
    ee_addr_q <= ee_addr_d;
  end

  // Storage arrays keep contents across reset
  always_ff @(posedge clock) begin
    if (pm_load.wr) begin
      pm_mem[pm_load.addr] <= pm_load.data;
    end
    if (bus_req.wr && region == RG_GPR) begin
      gpr_mem[eff_addr[4:0]] <= bus_req.wdata;
    end
    if (bus_req.wr && region == RG_SRAM) begin
      sram_mem[7'(eff_addr - SRAM_BASE)] <= bus_req.wdata;
    end
    if (other_io_wr) begin
      io_mem[io_idx] <= bus_req.wdata;
    end
    if (commit) begin
      ee_mem[ee_addr_q] <= data_q;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  chk_write_stall: assert property (
    launch |=> cpu_stall_q [*2] ##1 !cpu_stall_q)
    else $error("write launch did not stall exactly two cycles");

  chk_read_stall: assert property (
    rd_launch |=> (cpu_stall_q && state_q == EE_RD_STALL) [*4] ##1 !cpu_stall_q)
    else $error("read launch did not stall exactly four cycles");

  chk_arm_timeout: assert property (
    (ctrl_wr && bus_req.wdata[CTRL_ARM]) ##1 !(ctrl_wr && bus_req.wdata[CTRL_ARM]) [*4]
      |=> !arm_q)
    else $error("arm bit did not clear four cycles after set");

  chk_strobe_unarmed: assert property (
    (ctrl_wr && bus_req.wdata[CTRL_WR] && !arm_q && !busy_q) |=> !busy_q)
    else $error("unarmed write strobe started programming");

  chk_prog_end: assert property (
    $fell(busy_q) |-> $past(prog_cnt_q) == '0 && $past(busy_q, 2))
    else $error("programming ended before its interval");

  chk_busy_status: assert property (
    ctrl_rd |=> bus_rdata_q[CTRL_WR] == $past(busy_q) && bus_rdata_q[7:4] == 4'h0)
    else $error("control read does not show busy status");

  chk_irq_ready: assert property (
    ee_ready_irq_q == (irq_en_q && !busy_q))
    else $error("ready interrupt does not follow enable and idle");

  chk_addr_msb: assert property (
    addr_rd |=> !bus_rdata_q[7])
    else $error("address register bit 7 read as one");

  chk_unmapped_read: assert property (
    (bus_req.rd && !bus_req.is_io && bus_req.addr >= DS_END) |=> bus_rdata_q == 8'h00)
    else $error("address above the data map returned data");

  chk_pc_step: assert property (
    (!pc_load && !cpu_stall_q) |=> program_counter_q == PC_W'($past(program_counter_q) + 1'b1))
    else $error("program counter did not advance by one word");
endmodule : dme_top

// ==== testbench/dme_core_model.sv ====
`timescale 1ns/1ns
module dme_core_model
  import dme_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic cpu_stall_q, // Halt request from memory side
  input wire logic [7:0] bus_rdata_q, // Read data
  output dme_bus_req_t bus_req // Access toward memory side
);
  initial bus_req = '0;
  // One access per instruction; stall sampled over a short window afterwards
  task automatic acc(input logic [7:0] a, input logic io, w, r, input logic [7:0] d,
                     input int win, output logic [7:0] q, output int stl);
    int n;
    n = 0;
    while (cpu_stall_q === 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    bus_req <= '{addr: a, is_io: io, wr: w, rd: r, wdata: d};
    @(negedge clock);
    q = bus_rdata_q;
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b0;
    // Garbage data while idle so stale values never pass
    bus_req.wdata <= ~d;
    stl = 0;
    // At least one idle edge, so a strobe is never dropped and raised in one step
    repeat ((win > 0) ? win : 1) begin
      if (cpu_stall_q === 1'b1) stl++;
      @(negedge clock);
    end
  endtask : acc
endmodule : dme_core_model

// ==== testbench/dme_top_tb.sv ====
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module dme_top_tb;
  import dme_pkg::*;
  localparam int PROG = 20;
  typedef struct packed {logic chk; logic [7:0] exp;} dme_note_t;
  logic clock = 0;
  logic arst_n = 0;
  logic pc_load = 0;
  logic [PC_W-1:0] pc_target = '0;
  dme_pm_load_t pm_load = '0;
  dme_bus_req_t bus_req;
  logic [7:0] bus_rdata_q, rq, d, d2;
  logic cpu_stall_q, ee_ready_irq_q, rd_d = 0;
  logic [PC_W-1:0] program_counter_q;
  logic [PM_W-1:0] instr_word_q, w0, w1;
  int error_cnt = 0, comparisons = 0, stl, n, cyc = 0;
  logic [31:0] seed = 32'd90878;
  dme_note_t notes[$];
  dme_note_t note;
  logic [7:0] ea[2] = '{8'h00, 8'h7F};
  logic [7:0] eb[2];
  logic [7:0] map_a[6] = '{8'h00, 8'h1F, 8'h60, 8'hDF, 8'h25, 8'h5F};
  logic [7:0] map_r[6] = '{8'h00, 8'h1F, 8'h60, 8'hDF, 8'h05, 8'h3F};
  logic map_io[6] = '{0, 0, 0, 0, 1, 1};

  dme_top #(.PROG_CYCLES(PROG)) dut_u (.clock(clock), .arst_n(arst_n), .bus_req(bus_req),
    .pm_load(pm_load), .pc_load(pc_load), .pc_target(pc_target), .bus_rdata_q(bus_rdata_q),
    .cpu_stall_q(cpu_stall_q), .program_counter_q(program_counter_q),
    .instr_word_q(instr_word_q), .ee_ready_irq_q(ee_ready_irq_q));
  dme_core_model core_u (.clock(clock), .cpu_stall_q(cpu_stall_q), .bus_rdata_q(bus_rdata_q),
    .bus_req(bus_req));

  initial begin
    forever #20 clock = ~clock;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] v, input int win);
    core_u.acc(a, io, 1'b1, 1'b0, v, win, rq, stl);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic io, chk, input logic [7:0] e);
    notes.push_back('{chk, e});
    core_u.acc(a, io, 1'b0, 1'b1, 8'h00, 1, rq, stl);
  endtask : rd
  task automatic end_of_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  always @(posedge clock) rd_d <= bus_req.rd;
  always @(negedge clock) begin
    if (rd_d === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note.chk) `CHK("bus_rdata_q", note.exp, bus_rdata_q)
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(negedge clock);
    arst_n = 1;
    wr(IO_EE_ADDR, 1, 8'hFF, 1);
    rd(IO_EE_ADDR, 1, 1, 8'h7F);
    rd(8'h3E, 0, 1, 8'h7F);
    $display("test address_register done");
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      wr(map_a[i], 0, d, 0);
      rd(map_r[i], map_io[i], 1, d);
    end
    wr(8'hE0, 0, 8'h5A, 0);
    rd(8'hE0, 0, 1, 8'h00);
    $display("test data_map done");
    for (int i = 0; i < 2; i++) begin
      d = rnd();
      d2 = rnd();
      eb[i] = d2;
      wr(IO_EE_ADDR, 1, ea[i], 0);
      wr(IO_EE_DATA, 1, d, 0);
      wr(IO_EE_CTRL, 1, 8'h0C, 0);
      wr(IO_EE_CTRL, 1, 8'h0A, 6);
      `CHK("write stall", 2, stl)
      `CHK("irq while busy", 1'b0, ee_ready_irq_q)
      wr(IO_EE_DATA, 1, d2, 0);
      n = 0;
      do begin
        rd(IO_EE_CTRL, 1, 0, 8'h00);
        n++;
      end while (rq[1] === 1'b1 && n < 20);
      `CHK("busy seen", 1'b1, n > 1)
      `CHK("busy cleared", 1'b0, rq[1])
      `CHK("irq ready", 1'b1, ee_ready_irq_q)
    end
    for (int i = 0; i < 2; i++) begin
      wr(IO_EE_ADDR, 1, ea[i], 0);
      wr(IO_EE_CTRL, 1, 8'h01, 6);
      `CHK("read stall", 4, stl)
      rd(IO_EE_DATA, 1, 1, eb[i]);
    end
    $display("test eeprom_access done");
    wr(IO_EE_CTRL, 1, 8'h02, 6);
    `CHK("strobe unarmed", 0, stl)
    wr(IO_EE_CTRL, 1, 8'h04, 0);
    rd(IO_EE_CTRL, 1, 1, 8'h04);
    repeat (4) @(negedge clock);
    rd(IO_EE_CTRL, 1, 1, 8'h00);
    $display("test arm_timeout done");
    w0 = {rnd(), rnd()};
    w1 = {rnd(), rnd()};
    pm_load <= '{wr: 1'b1, addr: 10'h3FF, data: w1};
    @(negedge clock);
    pm_load <= '{wr: 1'b1, addr: 10'h000, data: w0};
    @(negedge clock);
    pm_load.wr <= 1'b0;
    pc_load <= 1'b1;
    pc_target <= 10'h3FF;
    @(negedge clock);
    pc_load <= 1'b0;
    `CHK("pc load", 10'h3FF, program_counter_q)
    @(negedge clock);
    `CHK("pc wrap", 10'h000, program_counter_q)
    `CHK("instr top", w1, instr_word_q)
    @(negedge clock);
    `CHK("instr zero", w0, instr_word_q)
    $display("test program_memory done");
    end_of_test();
  end
endmodule : dme_top_tb
